//--- rsdvs_top.sv
// set-point selection, voltage stepping, power good, boost and ldo control
`timescale 1ns/10ps
`default_nettype none

module rsdvs_top
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic standby_pin, // standby event, async
  input wire logic [1:0] current_limit_pin, // core buck limit, async
  input wire logic boost_heavy_load_pin, // boost load sense, async
  input wire logic system_reset_n, // reset pin, async, active low
  output logic [4:0][4:0] buck_code, // effective code per buck
  output logic [1:0] power_good_out, // core buck power good
  output logic [1:0] boost_vsel, // boost voltage select
  output logic boost_enable, // boost running
  output logic boost_pfm, // boost pulse-frequency operation
  output logic boost_always_switch, // boost always switching
  output logic [3:0] ldo_on, // ldo regulating
  output logic [3:0] ldo_low_power, // ldo reduced bias
  output logic [3:0] ldo_pulldown // ldo output pull-down on
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [rsdvs_pkg::NSYNC-1:0] pins_raw;
  logic [rsdvs_pkg::NSYNC-1:0] s1_q;
  logic [rsdvs_pkg::NSYNC-1:0] s2_q;
  logic [rsdvs_pkg::NSYNC-1:0] s3_q;
  logic [rsdvs_pkg::NSYNC-1:0] filt_q;
  logic stby_s;
  logic [1:0] ilim_s;
  logic heavy_s;
  logic rstpin_s;

  assign pins_raw = {system_reset_n, boost_heavy_load_pin,
                     current_limit_pin, standby_pin};

  // three stages; a level counts only once stages two and three agree,
  // which also rejects a single-cycle glitch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end
    else
    begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end

  assign stby_s = filt_q[0];
  assign ilim_s = filt_q[2:1];
  assign heavy_s = filt_q[3];
  assign rstpin_s = filt_q[4];

  // ----------------------------------------------------------------
  // apb slave: no wait state, answer registered in the setup cycle
  // ----------------------------------------------------------------
  logic [rsdvs_pkg::SP_W-1:0] norm_q [rsdvs_pkg::NUM_BUCK];
  logic [rsdvs_pkg::SP_W-1:0] stby_q [rsdvs_pkg::NUM_BUCK];
  logic [1:0] rate_q [rsdvs_pkg::NUM_CORE];
  logic [1:0] range4_q;
  logic [1:0] bst_v_q;
  logic [1:0] bst_mode_q;
  logic [1:0] bst_smode_q;
  logic [rsdvs_pkg::NUM_LDO-1:0] ldo_en_q;
  logic [rsdvs_pkg::NUM_LDO-1:0] ldo_resp_q;
  logic [rsdvs_pkg::NUM_LDO-1:0] ldo_mode_q;
  logic [1:0] fault_q;
  logic [rsdvs_pkg::CODE_W-1:0] target [rsdvs_pkg::NUM_BUCK];
  logic [rsdvs_pkg::CNT_W-1:0] interval [rsdvs_pkg::NUM_BUCK];
  logic [rsdvs_pkg::NUM_BUCK-1:0] busy;
  logic [rsdvs_pkg::BUCK_IDX_W-1:0] buck_idx;
  logic buck_hit;
  logic hit;
  logic wr_en;
  logic [31:0] rd_data;

  assign buck_idx = paddr[rsdvs_pkg::BUCK_IDX_LSB +: rsdvs_pkg::BUCK_IDX_W];
  assign buck_hit = (paddr <= rsdvs_pkg::OFS_BUCK5) && (paddr[1:0] == 2'h0);
  assign wr_en = psel && penable && pready && pwrite && hit;

  // address decode and read mux; set-point, boost and ldo reads show the stored fields, status and codes reads show live state
  always_comb
  begin
    rd_data = '0;
    hit = 1'b1;
    if (buck_hit)
    begin
      rd_data[rsdvs_pkg::F_NORM +: rsdvs_pkg::SP_W] = norm_q[buck_idx];
      rd_data[rsdvs_pkg::F_STBY +: rsdvs_pkg::SP_W] = stby_q[buck_idx];
      if (buck_idx < rsdvs_pkg::BUCK_IDX_W'(rsdvs_pkg::NUM_CORE))
        rd_data[rsdvs_pkg::F_RATE +: 2] = rate_q[buck_idx[0]];
      if (buck_idx == rsdvs_pkg::BUCK_IDX_W'(rsdvs_pkg::IDX_BUCK4))
        rd_data[rsdvs_pkg::F_RANGE +: 2] = range4_q;
    end
    else if (paddr == rsdvs_pkg::OFS_BOOST)
    begin
      rd_data[rsdvs_pkg::F_BST_V +: 2] = bst_v_q;
      rd_data[rsdvs_pkg::F_BST_MODE +: 2] = bst_mode_q;
      rd_data[rsdvs_pkg::F_BST_SMODE +: 2] = bst_smode_q;
    end
    else if (paddr == rsdvs_pkg::OFS_LDO)
    begin
      // programmed bits, not the standby-dependent state
      rd_data[rsdvs_pkg::F_LDO_EN +: rsdvs_pkg::NUM_LDO] = ldo_en_q;
      rd_data[rsdvs_pkg::F_LDO_RESP +: rsdvs_pkg::NUM_LDO] = ldo_resp_q;
      rd_data[rsdvs_pkg::F_LDO_MODE +: rsdvs_pkg::NUM_LDO] = ldo_mode_q;
    end
    else if (paddr == rsdvs_pkg::OFS_STATUS)
    begin
      rd_data[rsdvs_pkg::F_ST_BUSY +: rsdvs_pkg::NUM_BUCK] = busy;
      rd_data[rsdvs_pkg::F_ST_PG +: 2] = power_good_out;
      rd_data[rsdvs_pkg::F_ST_FAULT +: 2] = fault_q;
      rd_data[rsdvs_pkg::F_ST_STBY] = stby_s;
    end
    else if (paddr == rsdvs_pkg::OFS_CODES)
    begin
      for (int i = 0; i < rsdvs_pkg::NUM_BUCK; i++)
        rd_data[i*rsdvs_pkg::CODE_STRIDE +: rsdvs_pkg::CODE_W] = buck_code[i];
    end
    else
      hit = 1'b0;
  end

  // bus answer: ready raised for exactly the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      if (psel && !penable)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= !hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // regulator control registers
  // ----------------------------------------------------------------
  // set points; a write only moves the target, the stepper does the rest
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < rsdvs_pkg::NUM_BUCK; i++)
      begin
        norm_q[i] <= rsdvs_pkg::RST_SETPOINT;
        stby_q[i] <= rsdvs_pkg::RST_SETPOINT;
      end
      for (int i = 0; i < rsdvs_pkg::NUM_CORE; i++)
        rate_q[i] <= rsdvs_pkg::RST_RATE;
      range4_q <= rsdvs_pkg::RST_RANGE;
    end
    else if (wr_en && buck_hit)
    begin
      norm_q[buck_idx] <= pwdata[rsdvs_pkg::F_NORM +: rsdvs_pkg::SP_W];
      stby_q[buck_idx] <= pwdata[rsdvs_pkg::F_STBY +: rsdvs_pkg::SP_W];
      if (buck_idx < rsdvs_pkg::BUCK_IDX_W'(rsdvs_pkg::NUM_CORE))
        rate_q[buck_idx[0]] <= pwdata[rsdvs_pkg::F_RATE +: 2];
      if (buck_idx == rsdvs_pkg::BUCK_IDX_W'(rsdvs_pkg::IDX_BUCK4))
        range4_q <= pwdata[rsdvs_pkg::F_RANGE +: 2];
    end
  end

  // boost and ldo control words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bst_v_q <= rsdvs_pkg::RST_BOOST_V;
      bst_mode_q <= rsdvs_pkg::RSDVS_BST_AUTO;
      bst_smode_q <= rsdvs_pkg::RSDVS_BST_AUTO;
      ldo_en_q <= '0;
      ldo_resp_q <= '0;
      ldo_mode_q <= '0;
    end
    else if (wr_en && (paddr == rsdvs_pkg::OFS_BOOST))
    begin
      bst_v_q <= pwdata[rsdvs_pkg::F_BST_V +: 2];
      bst_mode_q <= pwdata[rsdvs_pkg::F_BST_MODE +: 2];
      bst_smode_q <= pwdata[rsdvs_pkg::F_BST_SMODE +: 2];
    end
    else if (wr_en && (paddr == rsdvs_pkg::OFS_LDO))
    begin
      ldo_en_q <= pwdata[rsdvs_pkg::F_LDO_EN +: rsdvs_pkg::NUM_LDO];
      ldo_resp_q <= pwdata[rsdvs_pkg::F_LDO_RESP +: rsdvs_pkg::NUM_LDO];
      ldo_mode_q <= pwdata[rsdvs_pkg::F_LDO_MODE +: rsdvs_pkg::NUM_LDO];
    end
  end

  // ----------------------------------------------------------------
  // target and rate selection, one stepper per buck
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < rsdvs_pkg::NUM_BUCK; i++)
    begin
      target[i] = stby_s ? stby_q[i][rsdvs_pkg::CODE_W-1:0]
                         : norm_q[i][rsdvs_pkg::CODE_W-1:0];
      interval[i] = rsdvs_pkg::CYC_4US;
    end
    // core bucks: host writes and standby moves share the selected rate
    for (int i = 0; i < rsdvs_pkg::NUM_CORE; i++)
    begin
      unique case (rate_q[i])
        2'b00: interval[i] = rsdvs_pkg::CYC_2US;
        2'b01: interval[i] = rsdvs_pkg::CYC_4US;
        2'b10: interval[i] = rsdvs_pkg::CYC_8US;
        2'b11: interval[i] = rsdvs_pkg::CYC_16US;
      endcase
    end
    interval[rsdvs_pkg::IDX_BUCK4] = (range4_q == rsdvs_pkg::RST_RANGE) ?
      rsdvs_pkg::CYC_8US : rsdvs_pkg::CYC_16US;
  end

  for (genvar g = 0; g < rsdvs_pkg::NUM_BUCK; g++)
  begin : g_step
    rsdvs_stepper u_step
    (
      .pclk(pclk),
      .presetn(presetn),
      .target(target[g]),
      .interval(interval[g]),
      .code_q(buck_code[g]),
      .busy_q(busy[g])
    );
  end

  // ----------------------------------------------------------------
  // power good and current-limit faults for the core bucks
  // ----------------------------------------------------------------
  // a fault latches only outside a transition; hardware set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_good_out <= '0;
      fault_q <= '0;
    end
    else
    begin
      for (int i = 0; i < rsdvs_pkg::NUM_CORE; i++)
      begin
        power_good_out[i] <= (buck_code[i] == target[i]) && !busy[i] &&
                             !ilim_s[i];
        fault_q[i] <= (fault_q[i] && !(wr_en &&
                       (paddr == rsdvs_pkg::OFS_STATUS) &&
                       pwdata[rsdvs_pkg::F_ST_FAULT + i])) ||
                      (ilim_s[i] && (buck_code[i] == target[i]));
      end
    end
  end

  // ----------------------------------------------------------------
  // boost mode decode and ldo state
  // ----------------------------------------------------------------
  rsdvs_pkg::rsdvs_bst_mode_t bst_act;
  logic [rsdvs_pkg::NUM_LDO-1:0] ldo_off;
  logic [rsdvs_pkg::NUM_LDO-1:0] ldo_lp;

  assign bst_act = rsdvs_pkg::rsdvs_bst_mode_t'(stby_s ? bst_smode_q
                                                       : bst_mode_q);

  // ldo truth table; a clear response bit masks standby entirely
  always_comb
  begin
    for (int i = 0; i < rsdvs_pkg::NUM_LDO; i++)
    begin
      ldo_off[i] = !ldo_en_q[i] || (ldo_resp_q[i] && stby_s &&
                   !(rsdvs_pkg::LDO_EXT_PASS[i] && ldo_mode_q[i]));
      ldo_lp[i] = ldo_en_q[i] && rsdvs_pkg::LDO_EXT_PASS[i] &&
                  ldo_mode_q[i] && (!ldo_resp_q[i] || stby_s);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boost_vsel <= rsdvs_pkg::RST_BOOST_V;
      boost_enable <= 1'b0;
      boost_pfm <= 1'b0;
      boost_always_switch <= 1'b0;
      ldo_on <= '0;
      ldo_low_power <= '0;
      ldo_pulldown <= '1;
    end
    else
    begin
      boost_vsel <= bst_v_q;
      boost_enable <= bst_act != rsdvs_pkg::RSDVS_BST_OFF;
      boost_pfm <= (bst_act == rsdvs_pkg::RSDVS_BST_PFM) ||
                   ((bst_act == rsdvs_pkg::RSDVS_BST_AUTO) && !heavy_s);
      boost_always_switch <= (bst_act == rsdvs_pkg::RSDVS_BST_APS) ||
                   ((bst_act == rsdvs_pkg::RSDVS_BST_AUTO) && heavy_s);
      ldo_on <= ~ldo_off & ~ldo_lp;
      ldo_low_power <= ldo_lp;
      ldo_pulldown <= ldo_off | {rsdvs_pkg::NUM_LDO{!rstpin_s}};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pg_low_moving;
    @(posedge pclk) disable iff (!presetn)
    (buck_code[0] != target[0]) |=> !power_good_out[0];
  endproperty
  a_pg_low_moving: assert property (p_pg_low_moving)
    else $error("power good high while stepping");

  property p_pg_low_limit;
    @(posedge pclk) disable iff (!presetn)
    ilim_s[1] |=> !power_good_out[1];
  endproperty
  a_pg_low_limit: assert property (p_pg_low_limit)
    else $error("power good high under current limit");

  property p_fault_masked;
    @(posedge pclk) disable iff (!presetn)
    !fault_q[0] && (buck_code[0] != target[0]) |=> !fault_q[0];
  endproperty
  a_fault_masked: assert property (p_fault_masked)
    else $error("fault latched during a transition");

  property p_boost_off;
    @(posedge pclk) disable iff (!presetn)
    (bst_act == rsdvs_pkg::RSDVS_BST_OFF) |=> !boost_enable && !boost_pfm;
  endproperty
  a_boost_off: assert property (p_boost_off)
    else $error("boost running in off mode");

  property p_ldo_pulldown;
    @(posedge pclk) disable iff (!presetn)
    !ldo_en_q[2] |=> ldo_pulldown[2] && !ldo_on[2];
  endproperty
  a_ldo_pulldown: assert property (p_ldo_pulldown)
    else $error("disabled ldo without pull-down");

  property p_reset_pulldown;
    @(posedge pclk) disable iff (!presetn)
    !rstpin_s |=> (&ldo_pulldown);
  endproperty
  a_reset_pulldown: assert property (p_reset_pulldown)
    else $error("pull-downs off while reset pin low");

  property p_no_stby_resp;
    @(posedge pclk) disable iff (!presetn)
    ldo_en_q[3] && !ldo_resp_q[3] ##1 $changed(stby_s) |-> ldo_on[3];
  endproperty
  a_no_stby_resp: assert property (p_no_stby_resp)
    else $error("ldo followed standby with response bit clear");

  sequence s_ldo_read;
    psel && !penable && !pwrite && (paddr == rsdvs_pkg::OFS_LDO);
  endsequence
  property p_read_programmed;
    @(posedge pclk) disable iff (!presetn)
    s_ldo_read |=> pready &&
      (prdata[rsdvs_pkg::F_LDO_EN +: rsdvs_pkg::NUM_LDO] == ldo_en_q);
  endproperty
  a_read_programmed: assert property (p_read_programmed)
    else $error("ldo read did not return programmed bits");
endmodule : rsdvs_top

`default_nettype wire

//--- rsdvs_stepper.sv
// shared constants and the per-regulator output-code stepper
`timescale 1ns/10ps
`default_nettype none

package rsdvs_pkg;
  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int NUM_BUCK = 5;
  localparam int NUM_CORE = 2;
  localparam int NUM_LDO = 4;
  localparam int SP_W = 6;
  localparam int CODE_W = 5;
  localparam int CNT_W = 11;
  localparam int NSYNC = 5;
  localparam logic [CODE_W-1:0] CODE_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

  // --------------------------------------------------------------
  // step timing: printed interval in microseconds, then cycles
  // --------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real NS_PER_US = 1000.0;
  localparam real T_STEP_2US = 2.0;
  localparam real T_STEP_4US = 4.0;
  localparam real T_STEP_8US = 8.0;
  localparam real T_STEP_16US = 16.0;
  localparam logic [CNT_W-1:0] CYC_2US =
    CNT_W'(int'(T_STEP_2US * NS_PER_US / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] CYC_4US =
    CNT_W'(int'(T_STEP_4US * NS_PER_US / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] CYC_8US =
    CNT_W'(int'(T_STEP_8US * NS_PER_US / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] CYC_16US =
    CNT_W'(int'(T_STEP_16US * NS_PER_US / CLK_PERIOD_NS));

  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_CORE1 = 8'h00;
  localparam logic [7:0] OFS_BUCK5 = 8'h10;
  localparam logic [7:0] OFS_BOOST = 8'h14;
  localparam logic [7:0] OFS_LDO = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_CODES = 8'h20;
  localparam int BUCK_IDX_LSB = 2;
  localparam int BUCK_IDX_W = 3;
  localparam int IDX_BUCK4 = 3;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int F_NORM = 0;
  localparam int F_STBY = 8;
  localparam int F_RATE = 16;
  localparam int F_RANGE = 16;
  localparam int F_BST_V = 0;
  localparam int F_BST_MODE = 4;
  localparam int F_BST_SMODE = 8;
  localparam int F_LDO_EN = 0;
  localparam int F_LDO_RESP = 8;
  localparam int F_LDO_MODE = 16;
  localparam int F_ST_BUSY = 0;
  localparam int F_ST_PG = 8;
  localparam int F_ST_FAULT = 12;
  localparam int F_ST_STBY = 16;
  localparam int CODE_STRIDE = 6;

  // --------------------------------------------------------------
  // reset values and encodings
  // --------------------------------------------------------------
  localparam logic [SP_W-1:0] RST_SETPOINT = 6'h00;
  localparam logic [1:0] RST_RATE = 2'h1;
  localparam logic [1:0] RST_RANGE = 2'h0;
  localparam logic [1:0] RST_BOOST_V = 2'h0;
  localparam logic [NUM_LDO-1:0] LDO_EXT_PASS = 4'h3;

  typedef enum logic [1:0] {
    RSDVS_BST_OFF = 2'b00,
    RSDVS_BST_PFM = 2'b01,
    RSDVS_BST_AUTO = 2'b10,
    RSDVS_BST_APS = 2'b11
  } rsdvs_bst_mode_t;
endpackage : rsdvs_pkg

// one regulator: walks its output code toward the target one code
// per step interval
module rsdvs_stepper
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [rsdvs_pkg::CODE_W-1:0] target, // selected set point
  input wire logic [rsdvs_pkg::CNT_W-1:0] interval, // cycles per step
  output logic [rsdvs_pkg::CODE_W-1:0] code_q, // effective output code
  output logic busy_q // transition in progress
);
  logic [rsdvs_pkg::CNT_W-1:0] tick_q;
  logic [rsdvs_pkg::CODE_W-1:0] code_d;
  logic step_due;

  // --------------------------------------------------------------
  // step timebase
  // --------------------------------------------------------------
  assign step_due = (tick_q == interval - rsdvs_pkg::CNT_ONE);

  // next code: one step at the end of each interval, never a jump
  always_comb
  begin
    code_d = code_q;
    if (step_due && (code_q < target))
      code_d = code_q + rsdvs_pkg::CODE_ONE;
    else if (step_due && (code_q > target))
      code_d = code_q - rsdvs_pkg::CODE_ONE;
  end

  // counter idles at zero so a new target waits a full interval
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_q <= rsdvs_pkg::CNT_ZERO;
    else if ((code_q == target) || step_due)
      tick_q <= rsdvs_pkg::CNT_ZERO;
    else
      tick_q <= tick_q + rsdvs_pkg::CNT_ONE;
  end

  // code and busy flag; done once the code equals the target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_q <= rsdvs_pkg::RST_SETPOINT[rsdvs_pkg::CODE_W-1:0];
      busy_q <= 1'b0;
    end
    else
    begin
      code_q <= code_d;
      busy_q <= (code_d != target);
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_one_code_step;
    @(posedge pclk) disable iff (!presetn)
    $changed(code_q) |->
      ((code_q - $past(code_q)) == rsdvs_pkg::CODE_ONE) ||
      (($past(code_q) - code_q) == rsdvs_pkg::CODE_ONE);
  endproperty
  a_one_code_step: assert property (p_one_code_step)
    else $error("code moved by more than one step");

  property p_step_spacing;
    @(posedge pclk) disable iff (!presetn)
    $changed(code_q) |-> ($past(tick_q) + rsdvs_pkg::CNT_ONE) ==
      $past(interval);
  endproperty
  a_step_spacing: assert property (p_step_spacing)
    else $error("code stepped before the interval ran out");

  property p_settled;
    @(posedge pclk) disable iff (!presetn)
    (code_q == target) && $stable(target) |=> !busy_q;
  endproperty
  a_settled: assert property (p_settled)
    else $error("busy stayed high after reaching target");
endmodule : rsdvs_stepper

`default_nettype wire

//--- rsdvs_proc_model.sv
// processor-side model that raises the standby event
`timescale 1ns/10ps
`default_nettype none

module rsdvs_proc_model
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic sleep_req, // bench asks for deep sleep
  output logic standby_pin // standby event to the device
);
  // launched on a clock edge like a gpio; the device syncs it anyway
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      standby_pin <= 1'b0;
    else
      standby_pin <= sleep_req;
  end
endmodule : rsdvs_proc_model

`default_nettype wire

//--- tb_top.sv
// bench: stepping, power good, boost and ldo control over apb
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  n_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end

module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic sleep_req, stby, heavy, sys_n, b_en, b_pfm, b_aps;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] lim, pg, vsel;
  logic [3:0] l_on, l_lp, l_pd;
  logic [4:0][4:0] code;
  int n_errors, check_count, seed, rt, tgv, tgs[2];
  rsdvs_top rsdvs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby_pin(stby), .current_limit_pin(lim),
    .boost_heavy_load_pin(heavy), .system_reset_n(sys_n),
    .buck_code(code), .power_good_out(pg), .boost_vsel(vsel),
    .boost_enable(b_en), .boost_pfm(b_pfm), .boost_always_switch(b_aps),
    .ldo_on(l_on), .ldo_low_power(l_lp), .ldo_pulldown(l_pd));
  rsdvs_proc_model rsdvs_proc_model_i (.pclk(pclk), .presetn(presetn),
    .sleep_req(sleep_req), .standby_pin(stby));
  // expected boost outputs {enable, pfm, always switching}
  function automatic logic [2:0] bst(input logic [1:0] m, input logic h);
    return {m != 2'h0, m == 2'h1 || (m == 2'h2 && !h),
      m == 2'h3 || (m == 2'h2 && h)};
  endfunction : bst
  // one apb transfer; an idle cycle follows so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // mid-walk the code must lag; half a step plus 40 cycles later it must sit on target
  task automatic walk(input int b, input int cyc, input logic [4:0] tg);
    int n;
    n = (tg > code[b]) ? tg - code[b] : code[b] - tg;
    repeat (cyc / 2 + (n - 1) * cyc) @(posedge pclk);
    `CHK("code mid", 1'b0, code[b] == tg)
    if (b < 2) `CHK("pg mid", 1'b0, pg[b])
    repeat (cyc / 2 + 40) @(posedge pclk);
    `CHK("code end", tg, code[b])
    if (b < 2) `CHK("pg end", 1'b1, pg[b])
  endtask : walk
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // watchdog, far beyond the longest expected run
  initial
  begin
    #1000000;
    n_errors++;
    stop_test();
  end
  initial
  begin
    seed = 32'hff8e;
    {psel, penable, pwrite, sleep_req, heavy, lim} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    sys_n = 1'b1;
    repeat (6) @(posedge pclk);
    `CHK("pd in reset", 4'hF, l_pd)
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("rate rst", 32'h00010000, r)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("boost rst", 32'h00000220, r)
    `CHK("vsel rst", 2'h0, vsel)
    `CHK("auto rst", 3'h6, {b_en, b_pfm, b_aps})
    apb(1'b0, 8'h24, 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("reset test done");
    for (int i = 0; i < 2; i++)
    begin
      rt = $random(seed) & 3;
      tgv = 2 + ($random(seed) & 7);
      tgs[i] = tgv;
      apb(1'b1, 8'(4 * i), 32'(rt << 16 | tgv));
      // limit pins stay quiet through timed walks, as forced switching would
      walk(i, 200 << rt, 5'(tgv));
    end
    lim <= 2'h1;
    repeat (8) @(posedge pclk);
    `CHK("pg limit", 2'h2, pg)
    lim <= 2'h0;
    repeat (8) @(posedge pclk);
    `CHK("pg clear", 2'h3, pg)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("fault held", 32'h00001300, r)
    `CHK("no err", 1'b0, err)
    apb(1'b1, 8'h1C, 32'h00001000);
    // buck one's limit raised while it is still stepping must not latch; buck two's does
    apb(1'b1, 8'h00, 32'(tgs[0] + 1));
    lim <= 2'h3;
    repeat (20) @(posedge pclk);
    `CHK("pg masked", 2'h0, pg)
    lim <= 2'h0;
    repeat (300) @(posedge pclk);
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("fault masked", 32'h00002300, r)
    apb(1'b1, 8'h08, 32'h4);
    walk(2, 400, 5'h4);
    apb(1'b1, 8'h0C, 32'h10003);
    walk(3, 1600, 5'h3);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("codes", 32'(tgs[0] + 1 + tgs[1] * 64) + 32'h000C4000, r)
    $display("host step test done");
    apb(1'b1, 8'h10, 32'h300);
    apb(1'b1, 8'h00, 32'(tgs[0]));
    sleep_req <= 1'b1;
    walk(0, 200, 5'h0);
    repeat (900) @(posedge pclk);
    `CHK("buck5 stby", 5'h3, code[4])
    apb(1'b0, 8'h00, 32'h0);
    `CHK("readback", 32'(tgs[0]), r)
    apb(1'b1, 8'h18, 32'h1050F);
    repeat (10) @(posedge pclk);
    `CHK("ldo on", 4'hA, l_on)
    `CHK("ldo low", 4'h1, l_lp)
    `CHK("ldo pd", 4'h4, l_pd)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("ldo read", 32'h0001050F, r)
    sleep_req <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK("ldo wake", 4'hF, l_on)
    $display("standby test done");
    for (int m = 0; m < 4; m++)
    begin
      heavy <= 1'($random(seed));
      apb(1'b1, 8'h14, 32'(m << 4 | m));
      repeat (10) @(posedge pclk);
      `CHK("boost v", 2'(m), vsel)
      `CHK("boost md", bst(2'(m), heavy), {b_en, b_pfm, b_aps})
    end
    sys_n <= 1'b0;
    repeat (8) @(posedge pclk);
    `CHK("pd pin", 4'hF, l_pd)
    $display("boost and pin test done");
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
